// File: verilog/sfcp_pkg.sv
// Purpose: constants and command decode for the serial flash command port
// Assumes: 8-bit opcodes followed by a 24-bit address phase
// Notes: opcode values are the command codes seen on the serial line
package sfcp_pkg;
  localparam int ADDR_W = 24;
  localparam int PAGE_W = 10;
  localparam int BYTE_W = 9;
  localparam int PAGE_LSB = 9;
  localparam int BLK_LSB = 3;
  localparam logic [9:0] WP_PAGES = 10'h100;
  localparam logic [5:0] OPC_LAST = 6'h07;
  localparam logic [5:0] ADDR_LAST = 6'h17;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] DUMMY_ARRAY = 3'h4;
  localparam logic [2:0] DUMMY_BUF = 3'h1;
  localparam logic [2:0] DUMMY_NONE = 3'h0;
  // pin vector positions
  localparam int P_CS = 0;
  localparam int P_SCK = 1;
  localparam int P_SI = 2;
  localparam int P_WP = 3;
  localparam int P_RST = 4;
  localparam int NPIN = 5;
  // select reads low and clock high until the pins are really seen
  localparam logic [4:0] PIN_RST = 5'h02;
  localparam logic MODE3_RST = 1'b1;
  // command flags
  localparam logic [7:0] F_ARR = 8'h01;
  localparam logic [7:0] F_BUF = 8'h02;
  localparam logic [7:0] F_B2 = 8'h04;
  localparam logic [7:0] F_RD = 8'h08;
  localparam logic [7:0] F_WD = 8'h10;
  localparam logic [7:0] F_PROG = 8'h20;
  localparam logic [7:0] F_NOADR = 8'h40;
  localparam logic [7:0] F_KNOWN = 8'h80;
  localparam logic [7:0] OP_BLK_ERASE = 8'h50;
  localparam logic [7:0] OP_PG_RD_A = 8'h52;
  localparam logic [7:0] OP_PG_RD_B = 8'hD2;
  localparam logic [7:0] OP_XFR1 = 8'h53;
  localparam logic [7:0] OP_XFR2 = 8'h55;
  localparam logic [7:0] OP_B1_RD_A = 8'h54;
  localparam logic [7:0] OP_B1_RD_B = 8'hD4;
  localparam logic [7:0] OP_B2_RD_A = 8'h56;
  localparam logic [7:0] OP_B2_RD_B = 8'hD6;
  localparam logic [7:0] OP_STAT_A = 8'h57;
  localparam logic [7:0] OP_STAT_B = 8'hD7;
  localparam logic [7:0] OP_REWR1 = 8'h58;
  localparam logic [7:0] OP_REWR2 = 8'h59;
  localparam logic [7:0] OP_CMP1 = 8'h60;
  localparam logic [7:0] OP_CMP2 = 8'h61;
  localparam logic [7:0] OP_CONT_A = 8'h68;
  localparam logic [7:0] OP_CONT_B = 8'hE8;
  localparam logic [7:0] OP_PG_ERASE = 8'h81;
  localparam logic [7:0] OP_THRU1 = 8'h82;
  localparam logic [7:0] OP_THRU2 = 8'h85;
  localparam logic [7:0] OP_PGM_E1 = 8'h83;
  localparam logic [7:0] OP_PGM_E2 = 8'h86;
  localparam logic [7:0] OP_BWR1 = 8'h84;
  localparam logic [7:0] OP_BWR2 = 8'h87;
  localparam logic [7:0] OP_PGM_N1 = 8'h88;
  localparam logic [7:0] OP_PGM_N2 = 8'h89;

  typedef struct packed {
    logic [7:0] f;
    logic [2:0] dummy;
  } cmd_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPC = 3'b001,
    ST_ADDR = 3'b010,
    ST_DUMMY = 3'b011,
    ST_DATA = 3'b100,
    ST_SKIP = 3'b101
  } st_e;

  function automatic cmd_s decode(input logic [7:0] opc);
    cmd_s d;
    d = '{F_KNOWN, DUMMY_NONE};
    case (opc)
      OP_BLK_ERASE, OP_PG_ERASE: d.f = F_KNOWN | F_ARR | F_PROG;
      OP_PG_RD_A, OP_PG_RD_B, OP_CONT_A, OP_CONT_B: d = '{F_KNOWN | F_ARR | F_RD, DUMMY_ARRAY};
      OP_XFR1, OP_CMP1: d.f = F_KNOWN | F_ARR;
      OP_XFR2, OP_CMP2: d.f = F_KNOWN | F_ARR | F_B2;
      OP_B1_RD_A, OP_B1_RD_B: d = '{F_KNOWN | F_BUF | F_RD, DUMMY_BUF};
      OP_B2_RD_A, OP_B2_RD_B: d = '{F_KNOWN | F_BUF | F_B2 | F_RD, DUMMY_BUF};
      OP_STAT_A, OP_STAT_B: d.f = F_KNOWN | F_RD | F_NOADR;
      OP_REWR1, OP_PGM_E1, OP_PGM_N1: d.f = F_KNOWN | F_ARR | F_PROG;
      OP_REWR2, OP_PGM_E2, OP_PGM_N2: d.f = F_KNOWN | F_ARR | F_PROG | F_B2;
      OP_THRU1: d.f = F_KNOWN | F_ARR | F_PROG | F_WD;
      OP_THRU2: d.f = F_KNOWN | F_ARR | F_PROG | F_WD | F_B2;
      OP_BWR1: d.f = F_KNOWN | F_BUF | F_WD;
      OP_BWR2: d.f = F_KNOWN | F_BUF | F_WD | F_B2;
      default: d.f = 8'h00;
    endcase
    return d;
  endfunction : decode
endpackage : sfcp_pkg

// File: verilog/serial_flash_command_port.sv
// Purpose: serial command port of a paged flash with two page buffers
// Assumes: mclk at 20 MHz, well above the serial clock rate
// Notes: pins pass three flops, so sck should stay below mclk / 8
//
// Summary of operation
// - opcode, five reserved bits, page, byte fields
// - dummy bytes: four array, one buffer, none status
// - sample on rising clock, shift out falling
// - deselected: input ignored, output high impedance
// - select fall starts, select rise ends command
// - protect low refuses programming lowest 256 pages
// - reset pin low aborts, sequencer goes idle
// - held in reset while reset pin low
// - internal power-on reset, independent of pin
// - ready/busy pulled low during self-timed operations
// - busy blocks array and busy buffer only
// - after reset: clock mode 3, output high impedance
// - fresh select fall needed after any reset
// - select fall samples clock idle level for mode
module serial_flash_command_port
  import sfcp_pkg::*;
(
  // system; resetn is the internal power-on reset
  input wire logic mclk,
  input wire logic resetn,
  // serial pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  output logic so_out,
  output logic so_oe,
  // protect and reset pins
  input wire logic wp_n,
  input wire logic rst_pin_n,
  // open-drain ready/busy
  output logic rdy_out,
  output logic rdy_oe,
  // array core side
  input wire logic array_busy,
  input wire logic busy_buf2,
  output logic hdr_valid,
  output logic [7:0] cmd_opcode,
  output logic [PAGE_W-1:0] cmd_page,
  output logic [BYTE_W-1:0] cmd_byte,
  output logic cmd_valid,
  output logic cmd_refused,
  output logic wr_valid,
  output logic [7:0] wr_data,
  output logic rd_req,
  input wire logic [7:0] rd_data,
  output logic spi_mode3,
  output logic op_abort
);

  logic [NPIN-1:0] pin_in, s1_reg, s2_reg, s3_reg, lvl_reg, agree, lvl_next;
  st_e state_reg, state_next;
  logic [5:0] cnt_reg, cnt_next;
  logic [ADDR_W-1:0] addr_reg;
  logic [7:0] opcode_reg, in_sh_reg, out_sh_reg, wr_data_reg, cmd_opcode_reg;
  logic [PAGE_W-1:0] cmd_page_reg;
  logic [BYTE_W-1:0] cmd_byte_reg;
  logic ld_reg, armed_reg, refuse_reg, refuse_next, mode3_reg, so_reg, so_oe_reg;
  logic rdy_oe_reg, abort_reg, hdr_reg, cmd_valid_reg, cmd_refused_reg, wr_valid_reg;
  logic rd_req_reg;

  // pin synchroniser: a level moves once stages two and three agree
  assign pin_in = {rst_pin_n, wp_n, si, sck, cs_n};
  assign agree = ~(s2_reg ^ s3_reg);
  assign lvl_next = (agree & s2_reg) | (~agree & lvl_reg);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s1_reg <= PIN_RST;
      s2_reg <= PIN_RST;
      s3_reg <= PIN_RST;
      lvl_reg <= PIN_RST;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  logic pin_rst, wp_ok, si_now, sck_rise, sck_fall, cs_fall, cs_rise, start;
  assign pin_rst = ~lvl_reg[P_RST];
  assign wp_ok = lvl_reg[P_WP];
  assign si_now = lvl_next[P_SI];
  assign sck_rise = lvl_next[P_SCK] & ~lvl_reg[P_SCK];
  assign sck_fall = ~lvl_next[P_SCK] & lvl_reg[P_SCK];
  assign cs_fall = lvl_reg[P_CS] & ~lvl_next[P_CS];
  assign cs_rise = ~lvl_reg[P_CS] & lvl_next[P_CS];
  // only a fall seen after select was really high starts a command
  assign start = cs_fall & armed_reg;

  // decode: the opcode is taken from the shifter on its last bit
  logic [7:0] opc_full;
  logic [ADDR_W-1:0] addr_full;
  cmd_s cmd;
  logic k_known, k_arr, k_buf, k_b2, k_rd, k_wd, k_prog, k_noadr;
  logic byte_done;
  logic [PAGE_W-1:0] page_raw;
  logic [PAGE_W-1:0] page_eff;
  logic busy_hit;
  logic wp_hit;
  logic [5:0] dummy_last;
  assign opc_full = {in_sh_reg[6:0], si_now};
  assign addr_full = {addr_reg[ADDR_W-2:0], si_now};
  assign cmd = decode((state_reg == ST_OPC) ? opc_full : opcode_reg);
  assign k_known = |(cmd.f & F_KNOWN);
  assign k_arr = |(cmd.f & F_ARR);
  assign k_buf = |(cmd.f & F_BUF);
  assign k_b2 = |(cmd.f & F_B2);
  assign k_rd = |(cmd.f & F_RD);
  assign k_wd = |(cmd.f & F_WD);
  assign k_prog = |(cmd.f & F_PROG);
  assign k_noadr = |(cmd.f & F_NOADR);
  assign byte_done = sck_rise & (cnt_reg[2:0] == BIT_LAST);
  assign page_raw = addr_full[PAGE_LSB +: PAGE_W];
  // block erase keeps the upper seven page bits; buffer ops drop the page
  assign page_eff = k_buf ? '0 :
    (opcode_reg == OP_BLK_ERASE) ? {page_raw[PAGE_W-1:BLK_LSB], BLK_LSB'(0)} :
    page_raw;
  assign busy_hit = array_busy & (k_arr | (k_buf & (k_b2 == busy_buf2)));
  assign wp_hit = k_prog & ~wp_ok & (page_eff < WP_PAGES);
  assign dummy_last = {cmd.dummy, 3'h0} - 6'h01;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    refuse_next = refuse_reg;
    if (sck_rise) begin
      cnt_next = cnt_reg + 6'h01;
    end
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_OPC;
          cnt_next = '0;
          refuse_next = 1'b0;
        end
      end
      ST_OPC: begin
        if (sck_rise && cnt_reg == OPC_LAST) begin
          cnt_next = '0;
          if (!k_known) begin
            state_next = ST_SKIP;
          end else if (busy_hit) begin
            state_next = ST_SKIP;
            refuse_next = 1'b1;
          end else if (k_noadr) begin
            state_next = ST_DATA;
          end else begin
            state_next = ST_ADDR;
          end
        end
      end
      ST_ADDR: begin
        if (sck_rise && cnt_reg == ADDR_LAST) begin
          cnt_next = '0;
          if (wp_hit) begin
            state_next = ST_SKIP;
            refuse_next = 1'b1;
          end else if (cmd.dummy != DUMMY_NONE) begin
            state_next = ST_DUMMY;
          end else begin
            state_next = ST_DATA;
          end
        end
      end
      ST_DUMMY: begin
        if (sck_rise && cnt_reg == dummy_last) begin
          cnt_next = '0;
          state_next = ST_DATA;
        end
      end
      default: begin
      end
    endcase
    if (cs_rise || pin_rst) begin
      state_next = ST_IDLE;
    end
  end

  logic enter_data;
  logic rd_go;
  assign enter_data = (state_next == ST_DATA) && (state_reg != ST_DATA);
  assign rd_go = (state_next == ST_DATA) && k_rd && (enter_data || byte_done);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      refuse_reg <= 1'b0;
      armed_reg <= 1'b0;
      mode3_reg <= MODE3_RST;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      refuse_reg <= refuse_next;
      armed_reg <= lvl_reg[P_CS] & ~pin_rst;
      if (pin_rst) begin
        mode3_reg <= MODE3_RST;
      end else if (start) begin
        mode3_reg <= lvl_reg[P_SCK];
      end
    end
  end

  // shifters: input on rising edges, output on falling edges
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      in_sh_reg <= '0;
      addr_reg <= '0;
      opcode_reg <= '0;
      out_sh_reg <= '0;
      ld_reg <= 1'b0;
      so_reg <= 1'b0;
      so_oe_reg <= 1'b0;
    end else begin
      if (sck_rise && state_reg != ST_IDLE) begin
        in_sh_reg <= opc_full;
      end
      if (sck_rise && state_reg == ST_ADDR) begin
        addr_reg <= addr_full;
      end
      if (state_reg == ST_OPC && state_next != ST_OPC) begin
        opcode_reg <= opc_full;
      end
      ld_reg <= rd_go;
      if (ld_reg) begin
        out_sh_reg <= rd_data;
      end else if (sck_fall && state_reg == ST_DATA) begin
        so_reg <= out_sh_reg[7];
        out_sh_reg <= {out_sh_reg[6:0], 1'b0};
      end
      // driven only while selected and returning data
      so_oe_reg <= (state_next == ST_DATA) && k_rd;
    end
  end

  // core handshakes
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hdr_reg <= 1'b0;
      cmd_valid_reg <= 1'b0;
      cmd_refused_reg <= 1'b0;
      wr_valid_reg <= 1'b0;
      wr_data_reg <= '0;
      rd_req_reg <= 1'b0;
      cmd_opcode_reg <= '0;
      cmd_page_reg <= '0;
      cmd_byte_reg <= '0;
      rdy_oe_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else begin
      hdr_reg <= enter_data;
      rd_req_reg <= rd_go;
      if (state_reg == ST_OPC && state_next != ST_OPC) begin
        cmd_opcode_reg <= opc_full;
      end
      if (state_reg == ST_ADDR && state_next != ST_ADDR) begin
        cmd_page_reg <= page_eff;
        cmd_byte_reg <= addr_full[BYTE_W-1:0];
      end
      // array work is launched only by the select rise
      cmd_valid_reg <= cs_rise && state_reg == ST_DATA && k_arr && !k_rd;
      cmd_refused_reg <= cs_rise && state_reg == ST_SKIP && refuse_reg;
      wr_valid_reg <= state_reg == ST_DATA && k_wd && byte_done && !cs_rise;
      if (byte_done) begin
        wr_data_reg <= opc_full;
      end
      rdy_oe_reg <= array_busy;
      abort_reg <= pin_rst;
    end
  end

  assign so_out = so_reg;
  assign so_oe = so_oe_reg;
  assign rdy_out = 1'b0;
  assign rdy_oe = rdy_oe_reg;
  assign hdr_valid = hdr_reg;
  assign cmd_opcode = cmd_opcode_reg;
  assign cmd_page = cmd_page_reg;
  assign cmd_byte = cmd_byte_reg;
  assign cmd_valid = cmd_valid_reg;
  assign cmd_refused = cmd_refused_reg;
  assign wr_valid = wr_valid_reg;
  assign wr_data = wr_data_reg;
  assign rd_req = rd_req_reg;
  assign spi_mode3 = mode3_reg;
  assign op_abort = abort_reg;

  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sequence s_addr_done;
    state_reg == ST_ADDR && sck_rise && cnt_reg == ADDR_LAST;
  endsequence
  sequence s_opc_done;
    state_reg == ST_OPC && sck_rise && cnt_reg == OPC_LAST;
  endsequence

  a_deselect_quiet: assert property (lvl_reg[P_CS] && $past(lvl_reg[P_CS]) |-> !so_oe)
    else $error("output driven while deselected");
  a_mode_pick: assert property (start && !pin_rst |=> spi_mode3 == $past(lvl_reg[P_SCK]))
    else $error("clock mode not taken from idle clock level");
  a_pin_reset_idle: assert property (pin_rst |=> state_reg == ST_IDLE ##1 !so_oe)
    else $error("pin reset did not idle the sequencer");
  a_reset_mode: assert property (pin_rst |=> spi_mode3 && op_abort)
    else $error("reset did not restore mode 3");
  a_busy_pin: assert property (array_busy |=> rdy_oe)
    else $error("busy not shown on ready pin");
  a_busy_block: assert property (s_opc_done ##0 busy_hit |=> state_reg == ST_SKIP ##0 refuse_reg)
    else $error("command accepted against busy resource");
  a_protect_refuse: assert property (s_addr_done ##0 wp_hit |=>
    state_reg == ST_SKIP [*1] ##0 refuse_reg)
    else $error("protected page accepted");
  a_fresh_fall: assert property (!armed_reg && state_reg == ST_IDLE |=> state_reg != ST_OPC)
    else $error("command started without fresh select fall");
  a_launch_end: assert property (cmd_valid |-> $past(cs_rise))
    else $error("command launched without select rise");
  a_shift_out: assert property (sck_fall && state_reg == ST_DATA && !ld_reg |=>
    so_out == $past(out_sh_reg[7]))
    else $error("output bit not shifted on falling edge");
endmodule : serial_flash_command_port

// File: bench/spi_host.sv
// Purpose: host controller model driving the serial pins of the command port
// Assumes: mclk runs far faster than the serial clock it makes
// Notes: HALF mclk cycles per serial clock phase, which keeps inside the sync limit
module spi_host (
  // system
  input wire logic mclk,
  // serial pins
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so_out,
  input wire logic so_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 6;
  logic idle;
  logic so_line;
  assign so_line = so_oe ? so_out : 1'bz;
  initial begin
    cs_n = 1'b1;
    sck = 1'b1;
    si = 1'b0;
    idle = 1'b1;
  end
  // a line nobody needs keeps moving, so a stale value is never mistaken for data
  always @(posedge mclk) begin
    if (idle) si <= ~si;
  end
  task automatic frame(input logic m3, input logic [71:0] bits, input int nb, input bit rd,
                       output logic [7:0] rdat);
    rdat = 8'h00;
    idle = 1'b0;
    @(posedge mclk);
    sck <= m3;
    repeat (HALF) @(posedge mclk);
    cs_n <= 1'b0;
    repeat (HALF) @(posedge mclk);
    for (int i = 0; i < nb + (rd ? 8 : 0); i++) begin
      sck <= 1'b0;
      si <= (i < nb) ? bits[71 - i] : ~si;
      repeat (HALF) @(posedge mclk);
      if (i >= nb) rdat = {rdat[6:0], so_line};
      sck <= 1'b1;
      repeat (HALF) @(posedge mclk);
    end
    if (!m3) sck <= 1'b0;
    repeat (HALF) @(posedge mclk);
    cs_n <= 1'b1;
    repeat (3 * HALF) @(posedge mclk);
    idle = 1'b1;
  endtask : frame
  task automatic noise(input int n);
    repeat (n) begin
      sck <= ~sck;
      repeat (HALF) @(posedge mclk);
    end
  endtask : noise
endmodule : spi_host

// File: bench/serial_flash_command_port_test.sv
// Purpose: self-checking bench for the serial flash command port
// Assumes: testbench plays the array core; spi_host plays the serial host
// Notes: power-up wait is cut to a few cycles to keep the run short
module serial_flash_command_port_test import sfcp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, resetn, wp_n, rst_pin_n, array_busy, busy_buf2, reading;
  logic cs_n, sck, si, so_out, so_oe, rdy_out, rdy_oe, hdr_valid, cmd_valid, cmd_refused;
  logic wr_valid, rd_req, spi_mode3, op_abort;
  logic [7:0] cmd_opcode, wr_data, rd_data, rd_byte, rdat, wb;
  logic [PAGE_W-1:0] cmd_page, pg;
  logic [BYTE_W-1:0] cmd_byte, by;
  int seed = 32'hf35b;
  int mismatches = 0;
  int checks = 0;
  int n_cmd = 0, n_ref = 0, n_wr = 0, n_hdr = 0, n_rq = 0, c0, r0, w0, h0, q0;
  logic [7:0] arr_ops [12] = '{8'h50, 8'h53, 8'h55, 8'h58, 8'h59, 8'h60, 8'h61, 8'h81,
                               8'h83, 8'h86, 8'h88, 8'h89};
  logic [7:0] rd_ops [10] = '{8'h57, 8'hD7, 8'h54, 8'hD4, 8'h56, 8'hD6, 8'h52, 8'hD2,
                              8'h68, 8'hE8};
  int rd_nb [10] = '{8, 8, 40, 40, 40, 40, 64, 64, 64, 64};

  serial_flash_command_port DUT (.mclk(mclk), .resetn(resetn), .cs_n(cs_n), .sck(sck),
    .si(si), .so_out(so_out), .so_oe(so_oe), .wp_n(wp_n), .rst_pin_n(rst_pin_n),
    .rdy_out(rdy_out), .rdy_oe(rdy_oe), .array_busy(array_busy), .busy_buf2(busy_buf2),
    .hdr_valid(hdr_valid), .cmd_opcode(cmd_opcode), .cmd_page(cmd_page),
    .cmd_byte(cmd_byte), .cmd_valid(cmd_valid), .cmd_refused(cmd_refused),
    .wr_valid(wr_valid), .wr_data(wr_data), .rd_req(rd_req), .rd_data(rd_data),
    .spi_mode3(spi_mode3), .op_abort(op_abort));
  spi_host host (.mclk(mclk), .cs_n(cs_n), .sck(sck), .si(si), .so_out(so_out),
    .so_oe(so_oe));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // core side: read data only holds during a read frame, noise otherwise
  always @(posedge mclk) begin
    rd_data <= reading ? rd_byte : 8'($random(seed));
    if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
    if (cmd_refused === 1'b1) n_ref <= n_ref + 1;
    if (wr_valid === 1'b1) n_wr <= n_wr + 1;
    if (hdr_valid === 1'b1) n_hdr <= n_hdr + 1;
    if (rd_req === 1'b1) n_rq <= n_rq + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic snap();
    c0 = n_cmd;
    r0 = n_ref;
    w0 = n_wr;
    h0 = n_hdr;
    q0 = n_rq;
  endtask : snap
  function automatic logic [71:0] hdr(input logic [7:0] op, input logic [9:0] p,
                                      input logic [8:0] b);
    return {op, 5'h00, p, b, 40'h00};
  endfunction : hdr
  // one array command; ok says whether it must launch or be refused
  task automatic arr_cmd(input logic m3, input logic [7:0] op, input logic [9:0] p,
                         input bit ok);
    snap();
    host.frame(m3, hdr(op, p, by), 32, 1'b0, rdat);
    check(n_cmd - c0, ok, "launch count");
    check(n_ref - r0, !ok, "refuse count");
  endtask : arr_cmd

  initial begin
    repeat (80000) @(posedge mclk);
    mismatches++;
    conclude();
  end

  initial begin
    resetn = 1'b0;
    wp_n = 1'b1;
    rst_pin_n = 1'b1;
    array_busy = 1'b0;
    busy_buf2 = 1'b0;
    reading = 1'b0;
    rd_byte = 8'h00;
    by = '0;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    check(so_oe, 1'b0, "so_oe after reset");
    check(spi_mode3, 1'b1, "mode after reset");
    check(rdy_oe, 1'b0, "ready after reset");
    $display("test reset done");
    for (int k = 0; k < 12; k++) begin
      pg = 10'h100 | 10'($random(seed));
      by = 9'($random(seed));
      arr_cmd(k[0], arr_ops[k], pg, 1'b1);
      check(cmd_opcode, arr_ops[k], "opcode");
      check(cmd_page, (arr_ops[k] == 8'h50) ? {pg[9:3], 3'h0} : pg, "page field");
      check(cmd_byte, by, "byte field");
      check(spi_mode3, k[0], "clock mode");
    end
    $display("test array commands done");
    wp_n <= 1'b0;
    arr_cmd(1'b0, 8'h81, 10'h0FF, 1'b0);
    arr_cmd(1'b1, 8'h81, 10'h100, 1'b1);
    arr_cmd(1'b1, 8'h50, 10'h0FF, 1'b0);
    wp_n <= 1'b1;
    arr_cmd(1'b0, 8'h81, 10'h0FF, 1'b1);
    $display("test protect done");
    array_busy <= 1'b1;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    check({rdy_oe, rdy_out}, 2'b10, "busy pin");
    arr_cmd(1'b1, 8'h55, 10'h200, 1'b0);
    wb = 8'($random(seed));
    snap();
    // the data byte follows the 32 header bits
    host.frame(1'b0, hdr(8'h87, 10'h000, by) | {32'h0, wb, 32'h0}, 40, 1'b0, rdat);
    check(n_wr - w0, 1, "buffer write count");
    check(wr_data, wb, "buffer write data");
    busy_buf2 <= 1'b1;
    arr_cmd(1'b1, 8'h87, 10'h000, 1'b0);
    array_busy <= 1'b0;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    check(rdy_oe, 1'b0, "ready pin");
    $display("test busy done");
    for (int k = 0; k < 10; k++) begin
      rd_byte = 8'($random(seed));
      reading = 1'b1;
      snap();
      host.frame(k[0], (k < 2) ? {rd_ops[k], 64'h0} :
                 hdr(rd_ops[k], 10'($random(seed)), 9'($random(seed))) | 40'($random(seed)),
                 rd_nb[k], 1'b1, rdat);
      reading = 1'b0;
      check(rdat, rd_byte, "read data");
      check(n_hdr - h0, 1, "header count");
      // one fetch on entering data, one more after the eighth data bit
      check(n_rq - q0, 2, "read requests");
      check(n_cmd - c0, 0, "read launches nothing");
      check(so_oe, 1'b0, "so_oe deselected");
    end
    $display("test reads done");
    snap();
    host.noise(20);
    @(negedge mclk);
    check(n_hdr - h0, 0, "deselected traffic");
    $display("test deselect done");
    snap();
    fork
      host.frame(1'b1, hdr(8'h88, 10'h300, 9'h000), 32, 1'b0, rdat);
      begin
        repeat (200) @(posedge mclk);
        rst_pin_n <= 1'b0;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        check({op_abort, so_oe, spi_mode3}, 3'b101, "abort state");
      end
    join
    rst_pin_n <= 1'b1;
    check(n_cmd - c0, 0, "aborted command");
    arr_cmd(1'b0, 8'h88, 10'h300, 1'b1);
    $display("test reset pin done");
    conclude();
  end
endmodule : serial_flash_command_port_test
